// ===== audio_clock_defines.svh
// Constants for the field locked audio clock generator
// -----------------------------------------------------------------------
// -----------------------------------------------------------------------
`ifndef AUDIO_CLOCK_DEFINES_SVH
`define AUDIO_CLOCK_DEFINES_SVH

// -----------------------------------------------------------------------
// Subaddresses
// -----------------------------------------------------------------------
`define ADDR_CPF_LOW 8'h30
`define ADDR_CPF_MID 8'h31
`define ADDR_CPF_HIGH 8'h32
`define ADDR_NI_LOW 8'h34
`define ADDR_NI_MID 8'h35
`define ADDR_NI_HIGH 8'h36
`define ADDR_BIT_DIV 8'h38
`define ADDR_CH_DIV 8'h39
`define ADDR_CONTROL 8'h3A
`define ADDR_RANGE_LOW 8'h30
`define ADDR_RANGE_HIGH 8'h3F

// -----------------------------------------------------------------------
// Field positions and widths
// -----------------------------------------------------------------------
`define CPF_W 18
`define NI_W 22
`define DIV_W 6
`define ACC_W 23
`define NI_SHIFT 23
`define CTRL_PLL_OPEN 3
`define CTRL_VREF_EXT 2
`define CTRL_CH_PHASE 1
`define CTRL_BIT_PHASE 0
`define CPF_HIGH_W 2
`define NI_HIGH_W 6
`define TRIM_SHIFT 4

// -----------------------------------------------------------------------
// Reset values (48 kHz x 256 from the first crystal, 50 Hz field)
// -----------------------------------------------------------------------
`define CPF_RESET 18'h3C000
`define NI_RESET 22'h30FBCE
`define BIT_DIV_RESET 6'h03
`define CH_DIV_RESET 6'h10
`define CTRL_RESET 8'h00

`endif

// ===== audio_clock_pkg.sv
// Types shared by the audio clock generator modules
package audio_clock_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [5:0] div_t;
    typedef enum logic [2:0] {
        LOCK_IDLE = 3'b001,
        LOCK_RUN = 3'b010,
        LOCK_TRIM = 3'b100
    } lock_state_t;
endpackage

// ===== audio_div_if.sv
// Divider settings carried from the register file to the divider chain
`timescale 1ns/1ps
interface audio_div_if;
    logic [5:0] bit_clock_div;
    logic [5:0] channel_clock_div;
    logic bit_clock_phase;
    logic channel_clock_phase;
    modport source (
        output bit_clock_div,
        output channel_clock_div,
        output bit_clock_phase,
        output channel_clock_phase
    );
    modport sink (
        input bit_clock_div,
        input channel_clock_div,
        input bit_clock_phase,
        input channel_clock_phase
    );
endinterface

// ===== audio_clock_divider.sv
// Bit clock and channel clock divider chain fed from the divider input pin
`timescale 1ns/1ps
`include "audio_clock_defines.svh"
module audio_clock_divider (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Looped master clock, sampled as a synchronous level
    input wire logic master_clock_divider_in,
    // Settings
    audio_div_if.sink cfg,
    // Divided clocks
    output logic serial_bit_clock,
    output logic channel_select_clock
);
    import audio_clock_pkg::*;

    logic mx_prev;
    logic mx_rise;
    logic mx_fall;
    logic mx_edge;
    logic [`DIV_W-1:0] bit_cnt;
    logic bit_prev;
    logic bit_edge;
    logic [`DIV_W-1:0] ch_cnt;

    // -------------------------------------------------------------------
    // Edge detection on the divider input
    // -------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mx_prev <= 1'b0;
        end else begin
            mx_prev <= master_clock_divider_in;
        end
    end
    assign mx_rise = master_clock_divider_in & ~mx_prev;
    assign mx_fall = ~master_clock_divider_in & mx_prev;
    // Phase picks which input edge moves the bit clock
    assign mx_edge = cfg.bit_clock_phase ? mx_rise : mx_fall;

    // Bit clock toggles every div+1 chosen input edges
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt <= '0;
            serial_bit_clock <= 1'b0;
        end else if (mx_edge) begin
            if (bit_cnt >= cfg.bit_clock_div) begin
                bit_cnt <= '0;
                serial_bit_clock <= ~serial_bit_clock;
            end else begin
                bit_cnt <= bit_cnt + 1'b1;
            end
        end
    end

    // -------------------------------------------------------------------
    // Channel clock from bit clock edges
    // -------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bit_prev <= 1'b0;
        end else begin
            bit_prev <= serial_bit_clock;
        end
    end
    assign bit_edge = cfg.channel_clock_phase ?
        (serial_bit_clock & ~bit_prev) :
        (~serial_bit_clock & bit_prev);

    // A divider of zero acts as one, having no legal meaning
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ch_cnt <= '0;
            channel_select_clock <= 1'b0;
        end else if (bit_edge) begin
            if (ch_cnt + 1'b1 >= cfg.channel_clock_div) begin
                ch_cnt <= '0;
                channel_select_clock <= ~channel_select_clock;
            end else begin
                ch_cnt <= ch_cnt + 1'b1;
            end
        end
    end
endmodule

// ===== field_locked_audio_clock_gen.sv
// Field locked audio master clock synthesiser with register file
`timescale 1ns/1ps
`include "audio_clock_defines.svh"
module field_locked_audio_clock_gen (
    // Crystal domain clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Strap for crystal selection, caught after reset release
    input wire logic crystal_select_strap,
    // Byte subaddress register port
    input wire logic reg_write,
    input wire logic reg_read,
    input wire audio_clock_pkg::byte_t reg_addr,
    input wire audio_clock_pkg::byte_t reg_wdata,
    output audio_clock_pkg::byte_t reg_rdata,
    // Vertical references
    input wire logic internal_vsync,
    input wire logic external_vsync,
    // Looped master clock input
    input wire logic master_clock_divider_in,
    // Audio clocks
    output logic synth_master_clock_out,
    output logic serial_bit_clock,
    output logic channel_select_clock,
    // Status
    output logic crystal_alt_selected,
    output logic field_locked
);
    import audio_clock_pkg::*;

    // -------------------------------------------------------------------
    // Register storage
    // -------------------------------------------------------------------
    logic [`CPF_W-1:0] clocks_per_field;
    logic [`NI_W-1:0] nominal_increment;
    div_t bit_clock_div;
    div_t channel_clock_div;
    logic pll_open_select;
    logic vertical_ref_select;
    logic channel_clock_phase;
    logic bit_clock_phase;
    logic strap_taken;

    // -------------------------------------------------------------------
    // Synthesiser state
    // -------------------------------------------------------------------
    logic [`ACC_W-1:0] phase_acc;
    logic [`NI_W:0] next_phase_step;
    logic [`ACC_W-1:0] next_phase_acc;
    logic signed [`NI_W:0] trim;
    logic [`CPF_W-1:0] clk_count;
    logic [`CPF_W-1:0] last_count;
    logic vref_prev;
    logic vref;
    logic vref_edge;
    logic synth_prev;
    logic synth_rise;
    lock_state_t lock_state;
    byte_t next_rdata;

    audio_div_if div_bus ();

    // Range check used for write decode only; reads decode each address
    function automatic logic in_audio_range(input byte_t a);
        in_audio_range = (a >= `ADDR_RANGE_LOW) && (a <= `ADDR_RANGE_HIGH);
    endfunction

    // -------------------------------------------------------------------
    // Register writes
    // -------------------------------------------------------------------
    // Writes outside the audio range are ignored by this block
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clocks_per_field <= `CPF_RESET;
            nominal_increment <= `NI_RESET;
            bit_clock_div <= `BIT_DIV_RESET;
            channel_clock_div <= `CH_DIV_RESET;
            pll_open_select <= 1'(`CTRL_RESET >> `CTRL_PLL_OPEN);
            vertical_ref_select <= 1'b0;
            channel_clock_phase <= 1'b0;
            bit_clock_phase <= 1'b0;
        end else if (reg_write && in_audio_range(reg_addr)) begin
            case (reg_addr)
                `ADDR_CPF_LOW: clocks_per_field[7:0] <= reg_wdata;
                `ADDR_CPF_MID: clocks_per_field[15:8] <= reg_wdata;
                `ADDR_CPF_HIGH: begin
                    clocks_per_field[17:16] <=
                        reg_wdata[`CPF_HIGH_W-1:0];
                end
                `ADDR_NI_LOW: nominal_increment[7:0] <= reg_wdata;
                `ADDR_NI_MID: nominal_increment[15:8] <= reg_wdata;
                `ADDR_NI_HIGH: begin
                    nominal_increment[21:16] <=
                        reg_wdata[`NI_HIGH_W-1:0];
                end
                `ADDR_BIT_DIV: bit_clock_div <= reg_wdata[`DIV_W-1:0];
                `ADDR_CH_DIV: channel_clock_div <= reg_wdata[`DIV_W-1:0];
                `ADDR_CONTROL: begin
                    pll_open_select <= reg_wdata[`CTRL_PLL_OPEN];
                    vertical_ref_select <= reg_wdata[`CTRL_VREF_EXT];
                    channel_clock_phase <= reg_wdata[`CTRL_CH_PHASE];
                    bit_clock_phase <= reg_wdata[`CTRL_BIT_PHASE];
                end
                default: begin
                end
            endcase
        end
    end

    // -------------------------------------------------------------------
    // Register reads
    // -------------------------------------------------------------------
    // Unused bits and unmapped addresses read as zero
    always_comb begin
        next_rdata = 8'h00;
        case (reg_addr)
            `ADDR_CPF_LOW: next_rdata = clocks_per_field[7:0];
            `ADDR_CPF_MID: next_rdata = clocks_per_field[15:8];
            `ADDR_CPF_HIGH: next_rdata = {6'h00, clocks_per_field[17:16]};
            `ADDR_NI_LOW: next_rdata = nominal_increment[7:0];
            `ADDR_NI_MID: next_rdata = nominal_increment[15:8];
            `ADDR_NI_HIGH: next_rdata = {2'h0, nominal_increment[21:16]};
            `ADDR_BIT_DIV: next_rdata = {2'h0, bit_clock_div};
            `ADDR_CH_DIV: next_rdata = {2'h0, channel_clock_div};
            `ADDR_CONTROL: begin
                next_rdata = {4'h0, pll_open_select, vertical_ref_select,
                    channel_clock_phase, bit_clock_phase};
            end
            default: next_rdata = 8'h00;
        endcase
    end

    // Read data is registered, valid the cycle after reg_read
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_read) begin
            reg_rdata <= next_rdata;
        end
    end

    // -------------------------------------------------------------------
    // Crystal strap
    // -------------------------------------------------------------------
    // Strap is taken on the first edge after release, never again
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_taken <= 1'b0;
            crystal_alt_selected <= 1'b0;
        end else if (!strap_taken) begin
            strap_taken <= 1'b1;
            crystal_alt_selected <= crystal_select_strap;
        end
    end

    // -------------------------------------------------------------------
    // Vertical reference selection and edge
    // -------------------------------------------------------------------
    assign vref = vertical_ref_select ? external_vsync
                                      : internal_vsync;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vref_prev <= 1'b0;
        end else begin
            vref_prev <= vref;
        end
    end
    assign vref_edge = vref & ~vref_prev;

    // -------------------------------------------------------------------
    // Phase accumulator running on the crystal clock
    // -------------------------------------------------------------------
    // Increment is nominal plus trim, nominal alone with the loop open; the accumulator MSB is the
    // synthesised clock, at step/2^23 times the crystal rate;
    // its jitter is one crystal period
    always_comb begin
        if (pll_open_select) begin
            next_phase_step = {1'b0, nominal_increment};
        end else begin
            next_phase_step = {1'b0, nominal_increment} + trim;
        end
        next_phase_acc = phase_acc + next_phase_step;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_acc <= '0;
            synth_master_clock_out <= 1'b0;
        end else begin
            phase_acc <= next_phase_acc;
            synth_master_clock_out <= next_phase_acc[`ACC_W-1];
        end
    end

    // -------------------------------------------------------------------
    // Field lock: count master clocks between vertical references
    // -------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            synth_prev <= 1'b0;
        end else begin
            synth_prev <= synth_master_clock_out;
        end
    end
    assign synth_rise = synth_master_clock_out & ~synth_prev;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_count <= '0;
            last_count <= '0;
        end else if (vref_edge) begin
            last_count <= clk_count;
            clk_count <= {{(`CPF_W-1){1'b0}}, synth_rise};
        end else if (synth_rise) begin
            clk_count <= clk_count + 1'b1;
        end
    end

    // Lock state: idle until first reference, then trim once per field
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lock_state <= LOCK_IDLE;
        end else begin
            case (lock_state)
                LOCK_IDLE: if (vref_edge) lock_state <= LOCK_RUN;
                LOCK_RUN: if (vref_edge) lock_state <= LOCK_TRIM;
                LOCK_TRIM: lock_state <= LOCK_RUN;
                default: lock_state <= LOCK_IDLE;
            endcase
        end
    end

    // Slow loop: nudge trim by a fixed step of 16 toward the target count per field.
    // A small step keeps jitter low at the cost of slow pull-in.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            trim <= '0;
            field_locked <= 1'b0;
        end else if (pll_open_select) begin
            trim <= '0;
            field_locked <= 1'b0;
        end else if (lock_state == LOCK_TRIM) begin
            field_locked <= (last_count == clocks_per_field);
            if (last_count < clocks_per_field) begin
                trim <= trim + (`NI_W+1)'(1 << `TRIM_SHIFT);
            end else if (last_count > clocks_per_field) begin
                trim <= trim - (`NI_W+1)'(1 << `TRIM_SHIFT);
            end
        end
    end

    // -------------------------------------------------------------------
    // Divider chain on the separate input pin
    // -------------------------------------------------------------------
    assign div_bus.bit_clock_div = bit_clock_div;
    assign div_bus.channel_clock_div = channel_clock_div;
    assign div_bus.bit_clock_phase = bit_clock_phase;
    assign div_bus.channel_clock_phase = channel_clock_phase;

    // Only the dividers see the looped input; lets it be our output
    audio_clock_divider u_divider (
        .clk(clk),
        .rst_n(rst_n),
        .master_clock_divider_in(master_clock_divider_in),
        .cfg(div_bus),
        .serial_bit_clock(serial_bit_clock),
        .channel_select_clock(channel_select_clock)
    );
endmodule

// ===== audio_clock_far_side.sv
// Far side model: divider clock source and consumer of the audio clocks
`timescale 1ns/1ps
module audio_clock_far_side (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Source choice and clocks from the block
    input wire logic loop_back,
    input wire logic synth_master_clock_out,
    input wire logic serial_bit_clock,
    input wire logic channel_select_clock,
    // Clock returned to the divider pin
    output logic master_clock_divider_in,
    // Activity counts
    output logic [31:0] master_rises,
    output logic [31:0] bit_toggles,
    output logic [31:0] ch_toggles
);
    logic clean_clk;
    logic [1:0] phase_cnt;
    logic prev_in, prev_bit, prev_ch;
    // Cleaned clock stand-in, period six cycles, runs free
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_cnt <= 2'h0;
            clean_clk <= 1'b0;
        end else if (phase_cnt == 2'h2) begin
            phase_cnt <= 2'h0;
            clean_clk <= ~clean_clk;
        end else begin
            phase_cnt <= phase_cnt + 2'h1;
        end
    end
    // Loop the synthesised clock back onto the divider pin when loop_back is set, else the stand-in
    assign master_clock_divider_in = loop_back ? synth_master_clock_out
        : clean_clk;
    // Read as differences, so reset only clears them
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_in <= 1'b0;
            prev_bit <= 1'b0;
            prev_ch <= 1'b0;
            master_rises <= 32'h0;
            bit_toggles <= 32'h0;
            ch_toggles <= 32'h0;
        end else begin
            prev_in <= master_clock_divider_in;
            prev_bit <= serial_bit_clock;
            prev_ch <= channel_select_clock;
            master_rises <= master_rises
                + {31'h0, master_clock_divider_in & ~prev_in};
            bit_toggles <= bit_toggles + {31'h0, serial_bit_clock ^ prev_bit};
            ch_toggles <= ch_toggles + {31'h0, channel_select_clock ^ prev_ch};
        end
    end
endmodule

// ===== audio_clock_gen_asserts.sv
// Port level checker of the field locked audio clock generator
`timescale 1ns/1ps
module audio_clock_gen_asserts (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Inputs
    input wire logic crystal_select_strap,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire audio_clock_pkg::byte_t reg_addr,
    input wire audio_clock_pkg::byte_t reg_wdata,
    input wire logic internal_vsync,
    input wire logic external_vsync,
    input wire logic master_clock_divider_in,
    // Outputs
    input wire audio_clock_pkg::byte_t reg_rdata,
    input wire logic synth_master_clock_out,
    input wire logic serial_bit_clock,
    input wire logic channel_select_clock,
    input wire logic crystal_alt_selected,
    input wire logic field_locked
);
    import audio_clock_pkg::*;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    byte_t ctrl, ni_top, since_vref, since_synth;
    logic mi_d, sb_d, vr_d, synth_d, v_sel, m_edge, b_edge;
    // Chosen edges follow the phase bits as written
    assign v_sel = ctrl[2] ? external_vsync : internal_vsync;
    assign m_edge = ctrl[0] ? master_clock_divider_in & ~mi_d
        : ~master_clock_divider_in & mi_d;
    assign b_edge = ctrl[1] ? serial_bit_clock & ~sb_d
        : ~serial_bit_clock & sb_d;
    // Shadow of the written settings the checks need
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= 8'h00;
            ni_top <= 8'h30;
        end else if (reg_write && reg_addr == 8'h3A) begin
            ctrl <= {4'h0, reg_wdata[3:0]};
        end else if (reg_write && reg_addr == 8'h36) begin
            ni_top <= {2'h0, reg_wdata[5:0]};
        end
    end
    // Last samples and saturating event ages
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mi_d <= 1'b0;
            sb_d <= 1'b0;
            vr_d <= 1'b0;
            synth_d <= 1'b0;
            since_vref <= 8'hFF;
            since_synth <= 8'h00;
        end else begin
            mi_d <= master_clock_divider_in;
            sb_d <= serial_bit_clock;
            vr_d <= v_sel;
            synth_d <= synth_master_clock_out;
            if (v_sel && !vr_d) since_vref <= 8'h00;
            else if (since_vref != 8'hFF) since_vref <= since_vref + 8'h01;
            if (synth_master_clock_out != synth_d || reg_write) begin
                since_synth <= 8'h00;
            end else if (since_synth != 8'hFF) begin
                since_synth <= since_synth + 8'h01;
            end
        end
    end
    sequence s_ctrl_read;
        reg_read && reg_addr == 8'h3A;
    endsequence
    sequence s_hole_read;
        reg_read && !(reg_addr inside {[8'h30:8'h32], [8'h34:8'h36],
            8'h38, 8'h39, 8'h3A});
    endsequence
    property p_hole_zero;
        s_hole_read |=> reg_rdata == 8'h00;
    endproperty
    a_hole_zero: assert property (p_hole_zero)
        else $error("unmapped read not zero");
    property p_ctrl_read;
        s_ctrl_read |=> reg_rdata == ctrl;
    endproperty
    a_ctrl_read: assert property (p_ctrl_read)
        else $error("control readback wrong");
    property p_bit_phase;
        $changed(serial_bit_clock) |->
            $past(m_edge) || $past(m_edge, 2) || $past(m_edge, 3);
    endproperty
    a_bit_phase: assert property (p_bit_phase)
        else $error("bit clock moved off the chosen edge");
    property p_ch_phase;
        $changed(channel_select_clock) |-> b_edge || $past(b_edge)
            || $past(b_edge, 2) || $past(b_edge, 3);
    endproperty
    a_ch_phase: assert property (p_ch_phase)
        else $error("channel clock moved off the chosen edge");
    property p_lock_on_vref;
        $changed(field_locked) && !ctrl[3] && !$past(ctrl[3])
            |-> since_vref <= 8'h04;
    endproperty
    a_lock_on_vref: assert property (p_lock_on_vref)
        else $error("lock changed away from a reference");
    property p_open_unlocked;
        ctrl[3] && $past(ctrl[3]) |-> !field_locked;
    endproperty
    a_open_unlocked: assert property (p_open_unlocked)
        else $error("lock shown with loop open");
    property p_strap;
        $rose(rst_n) |=> crystal_alt_selected == $past(crystal_select_strap);
    endproperty
    a_strap: assert property (p_strap)
        else $error("strap not captured");
    property p_synth_runs;
        ni_top >= 8'h10 |-> since_synth < 8'h0C;
    endproperty
    a_synth_runs: assert property (p_synth_runs)
        else $error("master clock stalled");
endmodule
bind field_locked_audio_clock_gen audio_clock_gen_asserts chk (
    .clk(clk), .rst_n(rst_n), .crystal_select_strap(crystal_select_strap),
    .reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .internal_vsync(internal_vsync),
    .external_vsync(external_vsync), .reg_rdata(reg_rdata),
    .master_clock_divider_in(master_clock_divider_in),
    .synth_master_clock_out(synth_master_clock_out),
    .serial_bit_clock(serial_bit_clock),
    .channel_select_clock(channel_select_clock),
    .crystal_alt_selected(crystal_alt_selected), .field_locked(field_locked)
);

// ===== test_field_locked_audio_clock_gen.sv
// Testbench of the field locked audio clock generator
`timescale 1ns/1ps
module test_field_locked_audio_clock_gen;
    import audio_clock_pkg::*;
    logic clk, rst_n, strap, wr_en, rd_en, int_v, ext_v, loop_back;
    logic mclk_in, synth_out, bit_clk, ch_clk, alt_sel, locked;
    logic [31:0] rises, bit_tog, ch_tog;
    byte_t addr, wdata, rdata;
    int mismatches, compares, cycles;
    byte_t addrs [14] = '{8'h30, 8'h31, 8'h32, 8'h34, 8'h35, 8'h36, 8'h38,
        8'h39, 8'h3A, 8'h33, 8'h37, 8'h3B, 8'h3F, 8'h40};
    byte_t resets [14] = '{8'h00, 8'hC0, 8'h03, 8'hCE, 8'hFB, 8'h30, 8'h03,
        8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    byte_t masks [14] = '{8'hFF, 8'hFF, 8'h03, 8'hFF, 8'hFF, 8'h3F, 8'h3F,
        8'h3F, 8'h0F, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    field_locked_audio_clock_gen uut (.clk(clk), .rst_n(rst_n),
        .crystal_select_strap(strap), .reg_write(wr_en), .reg_read(rd_en),
        .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata),
        .internal_vsync(int_v), .external_vsync(ext_v),
        .master_clock_divider_in(mclk_in), .synth_master_clock_out(synth_out),
        .serial_bit_clock(bit_clk), .channel_select_clock(ch_clk),
        .crystal_alt_selected(alt_sel), .field_locked(locked));
    audio_clock_far_side far (.clk(clk), .rst_n(rst_n), .loop_back(loop_back),
        .synth_master_clock_out(synth_out), .serial_bit_clock(bit_clk),
        .channel_select_clock(ch_clk), .master_clock_divider_in(mclk_in),
        .master_rises(rises), .bit_toggles(bit_tog), .ch_toggles(ch_tog));
    // Crystal clock; internal field 1000 cycles, external 1600
    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        int_v <= (cycles % 1000) < 4;
        ext_v <= (cycles % 1600) < 4;
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            mismatches = mismatches + 1;
            summarize();
        end
    end
    task automatic summarize();
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, exp);
        compares = compares + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask
    // One unit of slack for the count phase
    function automatic logic [31:0] near(input logic [31:0] s, e);
        near = (s + 1 >= e && s <= e + 1) ? e : s;
    endfunction
    // One-cycle strobes with an idle edge between
    task automatic wr(input byte_t a, d);
        @(posedge clk);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input byte_t a, exp);
        @(posedge clk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        @(posedge clk);
        check(rdata, exp);
    endtask
    // Divider settings, then rates at the far side
    task automatic div_test(input byte_t b, c, ph);
        logic [31:0] r0, t0, l0, r, t, l, ce;
        wr(8'h38, b);
        wr(8'h39, c);
        wr(8'h3A, ph);
        repeat (40) @(posedge clk);
        r0 = rises;
        t0 = bit_tog;
        l0 = ch_tog;
        repeat (1200) @(posedge clk);
        r = rises - r0;
        t = bit_tog - t0;
        l = ch_tog - l0;
        ce = (c == 8'h00) ? 32'h1 : {24'h0, c};
        check(near(t, r / (b + 1)), r / (b + 1));
        check(near(l, t / (2 * ce)), t / (2 * ce));
        $display("divider test %0h/%0h done", b, c);
    endtask
    // Lock state after a control write and a few fields
    task automatic lock_test(input byte_t ctl, input logic exp);
        wr(8'h3A, ctl);
        repeat (5000) @(posedge clk);
        check(locked, exp);
        $display("lock test %0h done", ctl);
    endtask
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        strap = 1'b0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        loop_back = 1'b0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        check(alt_sel, 1'b0);
        for (int i = 0; i < 14; i++) rd(addrs[i], resets[i]);
        for (int i = 0; i < 14; i++) wr(addrs[i], 8'hFF);
        for (int i = 0; i < 14; i++) rd(addrs[i], masks[i]);
        $display("register test done");
        wr(8'h36, 8'h10);
        wr(8'h35, 8'h00);
        wr(8'h34, 8'h00);
        div_test(8'h00, 8'h01, 8'h03);
        div_test(8'h01, 8'h02, 8'h00);
        div_test(8'h03, 8'h10, 8'h01);
        div_test(8'h07, 8'h08, 8'h02);
        div_test(8'h3F, 8'h01, 8'h00);
        div_test(8'h00, 8'h00, 8'h03);
        loop_back <= 1'b1;
        div_test(8'h01, 8'h04, 8'h03);
        // Master clock period is 8 cycles: 200 per external field
        wr(8'h30, 8'hC8);
        wr(8'h31, 8'h00);
        wr(8'h32, 8'h00);
        lock_test(8'h0C, 1'b0);
        lock_test(8'h04, 1'b1);
        lock_test(8'h00, 1'b0);
        lock_test(8'h0C, 1'b0);
        lock_test(8'h04, 1'b1);
        rst_n <= 1'b0;
        strap <= 1'b1;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        check(alt_sel, 1'b1);
        rd(8'h3A, 8'h00);
        $display("strap test done");
        summarize();
    end
endmodule
